// ===== pkg/afc_regs.svh
// register offsets, field positions, reset values and timing counts of the output format and power control
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH

// register offsets on the 8-bit control port
`define AFC_ADDR_DIV        8'h70
`define AFC_ADDR_PWR        8'h71
`define AFC_ADDR_DLL        8'h72
`define AFC_ADDR_OUTCTL     8'h73
`define AFC_ADDR_STATUS     8'h74

// output control fields
`define AFC_OUTCTL_FMT_LSB  0
`define AFC_OUTCTL_FMT_MSB  1
`define AFC_OUTCTL_CMOS     2
`define AFC_OUTCTL_DDR      3
`define AFC_OUTCTL_LOWDRV   4
`define AFC_OUTCTL_RESET    8'h00

// divider control fields
`define AFC_DIV_RATIO_LSB   0
`define AFC_DIV_RATIO_MSB   1
`define AFC_DIV_OVR         2
`define AFC_DIV_SLIP        3
`define AFC_DIV_RESET       8'h00

// power control fields
`define AFC_PWR_STATE_LSB   0
`define AFC_PWR_STATE_MSB   1
`define AFC_PWR_OVR         2
`define AFC_PWR_RESET       8'h00

// loop range field, zero selects the fast range
`define AFC_DLL_SLOW        0
`define AFC_DLL_RESET       8'h00

// status fields
`define AFC_STAT_LOCK       0
`define AFC_STAT_DIV_LSB    1
`define AFC_STAT_DIV_MSB    2
`define AFC_STAT_PWR_LSB    3
`define AFC_STAT_PWR_MSB    4
`define AFC_STAT_STRAP      5

// three-level strap pin codes
`define AFC_STRAP_LOW       2'b00
`define AFC_STRAP_FLOAT     2'b01
`define AFC_STRAP_HIGH      2'b10

// sample code geometry
`define AFC_CODE_MAX        16'sh1FFF
`define AFC_CODE_MIN        -16'sh2000
`define AFC_CODE_MID        14'h2000

// pipeline latency in sample periods
`define AFC_LATENCY         10

// loop relock: time in ns at the reference rate in MSPS, counted in samples
`define AFC_RELOCK_TIME_NS  100000
`define AFC_RELOCK_REF_MSPS 125
`define AFC_RELOCK_SAMPLES  ((`AFC_RELOCK_TIME_NS * `AFC_RELOCK_REF_MSPS) / 1000)

// clock cycles of strap synchroniser settling before straps are taken
`define AFC_STRAP_SETTLE    2'h3

`endif

// ===== pkg/afc_pkg.sv
// types shared by the output format and power control block
package afc_pkg;

    typedef enum logic [1:0] {
        AFC_FMT_TWOS,
        AFC_FMT_GRAY,
        AFC_FMT_OFFSET
    } afc_fmt_e;

    typedef enum logic [1:0] {
        AFC_PWR_NORMAL,
        AFC_PWR_SLEEP,
        AFC_PWR_NAP
    } afc_pwr_e;

    typedef enum logic [1:0] {
        AFC_DIV_1,
        AFC_DIV_2,
        AFC_DIV_4
    } afc_div_e;

    typedef logic [13:0] afc_code_t;

endpackage

// ===== core/afc_delay_line.sv
// parameterised shift line with advance enable, used for the sample pipeline and pin synchronisers
`timescale 1ns/1ns
`default_nettype none

module afc_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             adv_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] stage_r [DEPTH];

    // each stage only feeds the next, so a synchroniser's first flop has one reader
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_r[i] <= '0;
            end
        end else if (adv_i) begin
            stage_r[0] <= d_i;
            for (int i = 1; i < DEPTH; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign q_o = stage_r[DEPTH-1];

endmodule // afc_delay_line

`default_nettype wire

// ===== core/afc_format_power_ctrl.sv
// digital side of the converter: code formatting, over-range, bus modes, divider, loop relock, power states
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "afc_regs.svh"

module afc_format_power_ctrl #(
    parameter int RELOCK_SAMPLES = `AFC_RELOCK_SAMPLES
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // raw conversion result from the core, signed, wider than the code to show over-range
    input  wire logic signed [15:0] raw_code_i,
    // three-level strap pins, already resolved to codes, and divider sync pin
    input  wire logic [1:0]         divider_select_pin_i,
    input  wire logic [1:0]         power_state_pin_i,
    input  wire logic               divider_sync_reset_i,
    // register port
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [7:0]         reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [7:0]         reg_rdata_o,
    // sample bus toward the capture logic
    output logic      [13:0]        data_o,
    output logic                    data_oe_o,
    output logic                    over_range_o,
    output logic                    over_range_oe_o,
    output logic                    output_sample_clock_o,
    output logic                    output_sample_clock_oe_o,
    // pad and core controls
    output logic                    cmos_mode_o,
    output logic                    ddr_mode_o,
    output logic                    lvds_low_drive_o,
    output logic                    dll_slow_range_o,
    output logic                    dll_locked_o,
    output afc_pkg::afc_pwr_e       power_state_o
);
    import afc_pkg::*;

    localparam int CNT_W = $clog2(RELOCK_SAMPLES + 1);

    logic [7:0]     outctl_r;
    logic [7:0]     divctl_r;
    logic [7:0]     pwrctl_r;
    logic [7:0]     dllctl_r;
    logic           slip_req_r;
    logic [4:0]     pins_sync;
    logic [1:0]     div_strap_r;
    logic [1:0]     pwr_strap_r;
    logic [1:0]     settle_r;
    logic           strap_taken_r;
    afc_div_e       div_eff;
    afc_div_e       div_prev_r;
    afc_pwr_e       pwr_eff;
    logic [1:0]     div_cnt_r;
    logic           sample_stb;
    logic           sync_prev_r;
    logic [CNT_W-1:0] relock_cnt_r;
    logic           locked_r;
    logic signed [15:0] clamped;
    logic           over_range;
    afc_code_t      offset_code;
    afc_code_t      fmt_code;
    logic [14:0]    pipe_q;
    afc_code_t      word_r;
    logic           half_r;
    logic [13:0]    data_r;
    logic           or_r;
    logic           oclk_r;
    logic           oe_r;
    logic [7:0]     rdata_r;

    // strap and sync pins come from outside, two flops before any use
    afc_delay_line #(
        .WIDTH (5),
        .DEPTH (2)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .adv_i (1'b1),
        .d_i   ({divider_sync_reset_i, power_state_pin_i, divider_select_pin_i}),
        .q_o   (pins_sync)
    );

    // straps are taken once after reset release, when the synchroniser has settled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_r      <= 2'h0;
            strap_taken_r <= 1'b0;
            div_strap_r   <= `AFC_STRAP_FLOAT;
            pwr_strap_r   <= `AFC_STRAP_LOW;
        end else if (!strap_taken_r) begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == `AFC_STRAP_SETTLE) begin
                strap_taken_r <= 1'b1;
                div_strap_r   <= pins_sync[1:0];
                pwr_strap_r   <= pins_sync[3:2];
            end
        end
    end

    // control registers; slip is a write pulse and never stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            outctl_r   <= `AFC_OUTCTL_RESET;
            divctl_r   <= `AFC_DIV_RESET;
            pwrctl_r   <= `AFC_PWR_RESET;
            dllctl_r   <= `AFC_DLL_RESET;
            slip_req_r <= 1'b0;
        end else begin
            slip_req_r <= 1'b0;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `AFC_ADDR_OUTCTL: outctl_r <= reg_wdata_i;
                    `AFC_ADDR_DIV: begin
                        divctl_r   <= reg_wdata_i & 8'h07;
                        slip_req_r <= reg_wdata_i[`AFC_DIV_SLIP];
                    end
                    `AFC_ADDR_PWR: pwrctl_r <= reg_wdata_i & 8'h07;
                    `AFC_ADDR_DLL: dllctl_r <= reg_wdata_i & 8'h01;
                    default: ;
                endcase
            end
        end
    end

    // effective divider: register override first, then strap
    always_comb begin
        div_eff = AFC_DIV_1;
        if (divctl_r[`AFC_DIV_OVR]) begin
            case (divctl_r[`AFC_DIV_RATIO_MSB:`AFC_DIV_RATIO_LSB])
                2'h1:    div_eff = AFC_DIV_2;
                2'h2:    div_eff = AFC_DIV_4;
                default: div_eff = AFC_DIV_1;
            endcase
        end else begin
            case (div_strap_r)
                `AFC_STRAP_LOW:  div_eff = AFC_DIV_2;
                `AFC_STRAP_HIGH: div_eff = AFC_DIV_4;
                default:         div_eff = AFC_DIV_1;
            endcase
        end
    end

    // effective power state: register override first, then strap
    always_comb begin
        pwr_eff = AFC_PWR_NORMAL;
        if (pwrctl_r[`AFC_PWR_OVR]) begin
            case (pwrctl_r[`AFC_PWR_STATE_MSB:`AFC_PWR_STATE_LSB])
                2'h1:    pwr_eff = AFC_PWR_SLEEP;
                2'h2:    pwr_eff = AFC_PWR_NAP;
                default: pwr_eff = AFC_PWR_NORMAL;
            endcase
        end else begin
            case (pwr_strap_r)
                `AFC_STRAP_FLOAT: pwr_eff = AFC_PWR_SLEEP;
                `AFC_STRAP_HIGH:  pwr_eff = AFC_PWR_NAP;
                default:          pwr_eff = AFC_PWR_NORMAL;
            endcase
        end
    end

    // clock divider; slip holds the count one extra cycle, only when dividing
    assign sample_stb = (div_cnt_r == 2'h0);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_r   <= 2'h0;
            sync_prev_r <= 1'b0;
        end else begin
            sync_prev_r <= pins_sync[4];
            if (pins_sync[4] && !sync_prev_r) begin
                div_cnt_r <= 2'h0; // align phase on sync pin rising edge
            end else if (slip_req_r && div_eff != AFC_DIV_1) begin
                div_cnt_r <= div_cnt_r;
            end else if (sample_stb) begin
                case (div_eff)
                    AFC_DIV_2: div_cnt_r <= 2'h1;
                    AFC_DIV_4: div_cnt_r <= 2'h3;
                    default:   div_cnt_r <= 2'h0;
                endcase
            end else begin
                div_cnt_r <= div_cnt_r - 2'h1;
            end
        end
    end

    // loop relock counted in samples, so the time scales inversely with rate
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_prev_r   <= AFC_DIV_1;
            relock_cnt_r <= '0;
            locked_r     <= 1'b0;
        end else begin
            div_prev_r <= div_eff;
            if (div_eff != div_prev_r || !strap_taken_r) begin
                relock_cnt_r <= CNT_W'(RELOCK_SAMPLES);
                locked_r     <= 1'b0;
            end else if (sample_stb) begin
                if (relock_cnt_r != '0) begin
                    relock_cnt_r <= relock_cnt_r - 1'b1;
                end else begin
                    locked_r <= 1'b1;
                end
            end
        end
    end

    // saturate instead of wrapping, flag per sample
    always_comb begin
        over_range = 1'b0;
        clamped    = raw_code_i;
        if (raw_code_i > `AFC_CODE_MAX) begin
            over_range = 1'b1;
            clamped    = `AFC_CODE_MAX;
        end else if (raw_code_i < `AFC_CODE_MIN) begin
            over_range = 1'b1;
            clamped    = `AFC_CODE_MIN;
        end
    end

    // offset binary is the base every format is built from
    assign offset_code = clamped[13:0] ^ `AFC_CODE_MID;

    always_comb begin
        case (afc_fmt_e'(outctl_r[`AFC_OUTCTL_FMT_MSB:`AFC_OUTCTL_FMT_LSB]))
            AFC_FMT_OFFSET: fmt_code = offset_code;
            AFC_FMT_GRAY:   fmt_code = offset_code ^ (offset_code >> 1);
            default:        fmt_code = offset_code ^ `AFC_CODE_MID;
        endcase
    end

    // eleven sample periods from capture to pins, ten in this line and one in the bus register; flag travels beside its code
    afc_delay_line #(
        .WIDTH (15),
        .DEPTH (`AFC_LATENCY)
    ) u_pipe (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .adv_i (sample_stb),
        .d_i   ({over_range, fmt_code}),
        .q_o   (pipe_q)
    );

    // bus driver: sdr shows whole word, ddr upper half on rising clock, lower on falling
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_r <= '0;
            half_r <= 1'b0;
            data_r <= '0;
            or_r   <= 1'b0;
            oclk_r <= 1'b0;
        end else if (sample_stb) begin
            word_r <= pipe_q[13:0];
            or_r   <= pipe_q[14];
            half_r <= outctl_r[`AFC_OUTCTL_DDR];
            if (outctl_r[`AFC_OUTCTL_DDR]) begin
                data_r <= {7'h00, pipe_q[13:7]};
                oclk_r <= 1'b1;
            end else begin
                data_r <= pipe_q[13:0];
                oclk_r <= ~oclk_r;
            end
        end else if (half_r) begin
            // lower half needs a second clk inside the sample period; divide 1 cannot show it
            data_r <= {7'h00, word_r[6:0]};
            oclk_r <= 1'b0;
            half_r <= 1'b0;
        end
    end

    // every output pad floats unless the power state is normal
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= strap_taken_r && (pwr_eff == AFC_PWR_NORMAL);
        end
    end

    // read data one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `AFC_ADDR_OUTCTL: rdata_r <= outctl_r;
                `AFC_ADDR_DIV:    rdata_r <= divctl_r;
                `AFC_ADDR_PWR:    rdata_r <= pwrctl_r;
                `AFC_ADDR_DLL:    rdata_r <= dllctl_r;
                `AFC_ADDR_STATUS: rdata_r <= {2'h0, strap_taken_r, pwr_eff, div_eff, locked_r};
                default:          rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // pad controls registered so every output leaves a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmos_mode_o      <= 1'b0;
            ddr_mode_o       <= 1'b0;
            lvds_low_drive_o <= 1'b0;
            dll_slow_range_o <= 1'b0;
            power_state_o    <= AFC_PWR_NORMAL;
        end else begin
            cmos_mode_o      <= outctl_r[`AFC_OUTCTL_CMOS];
            ddr_mode_o       <= outctl_r[`AFC_OUTCTL_DDR];
            lvds_low_drive_o <= outctl_r[`AFC_OUTCTL_LOWDRV] && !outctl_r[`AFC_OUTCTL_CMOS];
            dll_slow_range_o <= dllctl_r[`AFC_DLL_SLOW];
            power_state_o    <= pwr_eff;
        end
    end

    assign reg_rdata_o              = rdata_r;
    assign data_o                   = data_r;
    assign over_range_o             = or_r;
    assign output_sample_clock_o    = oclk_r;
    assign data_oe_o                = oe_r;
    assign over_range_oe_o          = oe_r;
    assign output_sample_clock_oe_o = oe_r;
    assign dll_locked_o             = locked_r;

endmodule // afc_format_power_ctrl

`default_nettype wire

// ===== testbench/afc_fpc_chk.sv
// port assertions for the output format and power control block
`timescale 1ns/1ns
`default_nettype none

module afc_fpc_chk
    import afc_pkg::*;
#(
    parameter int RELOCK_SAMPLES = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [13:0] data_o,
    input wire logic        data_oe_o,
    input wire logic        over_range_o,
    input wire logic        over_range_oe_o,
    input wire logic        output_sample_clock_o,
    input wire logic        output_sample_clock_oe_o,
    input wire logic        cmos_mode_o,
    input wire logic        ddr_mode_o,
    input wire logic        lvds_low_drive_o,
    input wire logic        dll_slow_range_o,
    input wire logic        dll_locked_o,
    input wire afc_pwr_e    power_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // clocks spent unlocked, saturating so a long stall never wraps
    int unl_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) unl_r <= 0;
        else if (dll_locked_o) unl_r <= 0;
        else if (unl_r < 100000) unl_r <= unl_r + 1;
    end

    sequence s_outctl_wr;
        reg_wr_i && reg_addr_i == 8'h73;
    endsequence
    sequence s_dll_wr;
        reg_wr_i && reg_addr_i == 8'h72;
    endsequence

    property p_mode_wr;
        s_outctl_wr |-> ##2 {ddr_mode_o, cmos_mode_o} == $past(reg_wdata_i[3:2], 2);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("bus mode differs from written value");
    property p_lowdrv;
        s_outctl_wr |-> ##2 lvds_low_drive_o == ($past(reg_wdata_i[4], 2) && !$past(reg_wdata_i[2], 2));
    endproperty
    a_lowdrv: assert property (p_lowdrv) else $error("drive current setting wrong");
    property p_dll_wr;
        s_dll_wr |-> ##2 dll_slow_range_o == $past(reg_wdata_i[0], 2);
    endproperty
    a_dll_wr: assert property (p_dll_wr) else $error("loop range differs from written value");
    property p_hiz;
        power_state_o != AFC_PWR_NORMAL && $past(power_state_o) != AFC_PWR_NORMAL
            |-> !(data_oe_o || over_range_oe_o || output_sample_clock_oe_o);
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs driven while powered down");
    property p_or_rate;
        !ddr_mode_o && !$past(ddr_mode_o) && data_oe_o && $past(data_oe_o) && $changed(over_range_o)
            |-> $changed(output_sample_clock_o);
    endproperty
    a_or_rate: assert property (p_or_rate) else $error("flag changed between samples");
    property p_sat;
        !ddr_mode_o && !$past(ddr_mode_o) && $changed(output_sample_clock_o) && over_range_o && data_oe_o
            |-> data_o inside {14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
    endproperty
    a_sat: assert property (p_sat) else $error("flagged sample not saturated");
    property p_lock_wait;
        $rose(dll_locked_o) |-> unl_r >= RELOCK_SAMPLES;
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("loop locked too early");
    property p_rd_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule // afc_fpc_chk

bind afc_format_power_ctrl afc_fpc_chk #(.RELOCK_SAMPLES(RELOCK_SAMPLES)) afc_fpc_chk_inst (.*);

`default_nettype wire

// ===== testbench/afc_capture_model.sv
// capture side model: latches the resolved bus on output clock changes, undoes gray coding
`timescale 1ns/1ns
`default_nettype none

module afc_capture_model (
    input  wire logic        clk_i,
    input  wire logic [13:0] data_i,
    input  wire logic        oe_i,
    input  wire logic        oclk_i,
    output logic      [13:0] cap_o,
    output logic      [13:0] bin_o
);
    logic [13:0] last_r;
    logic [13:0] bus_v;
    logic        oclk_r;
    // a released bus shows the inverse of its last level so stale data never passes
    assign bus_v = oe_i ? data_i : ~last_r;
    // capture one cycle after the clock changes, when the word is settled
    always_ff @(posedge clk_i) begin
        if (oe_i) last_r <= data_i;
        oclk_r <= oclk_i;
        if (oe_i && oclk_i != oclk_r) cap_o <= bus_v;
    end
    // decode top bit down, each bit using the one recovered above it
    always_comb begin
        bin_o[13] = cap_o[13];
        for (int i = 12; i >= 0; i--) bin_o[i] = cap_o[i] ^ bin_o[i+1];
    end
endmodule // afc_capture_model

`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench of the output format and power control block
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; $display("FAIL %0t %h %h", $time, a, b); end end

module tb_top;
    import afc_pkg::*;
    typedef struct {logic [7:0] fmt; logic [15:0] raw; afc_code_t code; afc_code_t ofs; logic orng;} afc_row_s;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic signed [15:0] raw_code_i = '0;
    logic [1:0]         divider_select_pin_i = 2'b01;
    logic [1:0]         power_state_pin_i = 2'b00;
    logic               divider_sync_reset_i = 1'b0;
    logic [7:0]         reg_addr_i = '0;
    logic [7:0]         reg_wdata_i = '0;
    logic               reg_wr_i = 1'b0;
    logic               reg_rd_i = 1'b0;
    logic [7:0]         reg_rdata_o, rv;
    logic [13:0]        data_o, cap, bin;
    logic               data_oe_o, over_range_o, over_range_oe_o, output_sample_clock_o;
    logic               output_sample_clock_oe_o, cmos_mode_o, ddr_mode_o, lvds_low_drive_o;
    logic               dll_slow_range_o, dll_locked_o, o2;
    afc_pwr_e           power_state_o;
    int                 err_total = 0, n_compared = 0, cyc = 0, tn;
    // format, raw input, expected code, offset binary equivalent, flag
    afc_row_s rows [13] = '{
        '{8'h00, 16'h0000, 14'h0000, 14'h2000, 1'b0}, '{8'h00, 16'h1FFF, 14'h1FFF, 14'h3FFF, 1'b0},
        '{8'h00, 16'hE000, 14'h2000, 14'h0000, 1'b0}, '{8'h00, 16'h2328, 14'h1FFF, 14'h3FFF, 1'b1},
        '{8'h01, 16'h0000, 14'h3000, 14'h2000, 1'b0}, '{8'h01, 16'h1FFE, 14'h2001, 14'h3FFE, 1'b0},
        '{8'h01, 16'hE001, 14'h0001, 14'h0001, 1'b0}, '{8'h01, 16'hDCD8, 14'h0000, 14'h0000, 1'b1},
        '{8'h02, 16'h0000, 14'h2000, 14'h2000, 1'b0}, '{8'h02, 16'h1FFF, 14'h3FFF, 14'h3FFF, 1'b0},
        '{8'h02, 16'hE000, 14'h0000, 14'h0000, 1'b0}, '{8'h02, 16'h2328, 14'h3FFF, 14'h3FFF, 1'b1},
        '{8'h03, 16'h0000, 14'h0000, 14'h2000, 1'b0}};
    logic [1:0] straps [3] = '{2'b00, 2'b01, 2'b10};
    int         n_tog [3] = '{12, 24, 6};
    afc_pwr_e   pst [3] = '{AFC_PWR_NORMAL, AFC_PWR_SLEEP, AFC_PWR_NAP};

    afc_format_power_ctrl #(.RELOCK_SAMPLES(8)) afc_format_power_ctrl_inst (.*);
    afc_capture_model afc_capture_model_inst (.clk_i, .data_i(data_o), .oe_i(data_oe_o),
        .oclk_i(output_sample_clock_o), .cap_o(cap), .bin_o(bin));

    // clock never stops, also while powered down, so the loop stays locked
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // hang guard, far beyond the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic settle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask
    task automatic reset(logic [1:0] dp, logic [1:0] pp);
        @(posedge clk_i);
        rst_i <= 1'b1;
        divider_select_pin_i <= dp;
        power_state_pin_i <= pp;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(8);
    endtask
    // output clock changes in 24 clocks: one per sample in single rate mode
    task automatic toggles();
        logic o;
        settle(8);
        o = output_sample_clock_o;
        tn = 0;
        repeat (24) begin
            settle(1);
            tn += int'(output_sample_clock_o !== o);
            o = output_sample_clock_o;
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(8);
        for (int a = 8'h70; a < 8'h74; a++) begin
            rd(a[7:0]);
            `CHK(rv, 8'h00)
        end
        `CHK({cmos_mode_o, ddr_mode_o, lvds_low_drive_o, dll_slow_range_o}, 4'h0)
        // table of codings, boundary codes and over-range inputs
        foreach (rows[i]) begin
            wr(8'h73, rows[i].fmt);
            @(posedge clk_i) raw_code_i <= rows[i].raw;
            settle(14);
            `CHK(data_o, rows[i].code)
            `CHK(over_range_o, rows[i].orng)
            if (rows[i].fmt == 8'h01) `CHK(bin, rows[i].ofs)
        end
        // a flagged sample arrives exactly after eleven sample edges
        @(posedge clk_i) raw_code_i <= 16'h2328;
        settle(10);
        `CHK({over_range_o, data_o}, 15'h0000)
        settle(1);
        `CHK({over_range_o, data_o}, 15'h5FFF)
        for (int i = 0; i < 3; i++) begin
            reset(straps[i], 2'b00);
            toggles();
            `CHK(tn, n_tog[i])
            reset(2'b01, straps[i]);
            `CHK(power_state_o, pst[i])
            `CHK(data_oe_o, i == 0)
        end
        reset(2'b01, 2'b00);
        wr(8'h70, 8'h06);
        settle(4);
        `CHK(dll_locked_o, 1'b0)
        toggles();
        `CHK(tn, 6)
        for (int k = 0; k < 200 && dll_locked_o !== 1'b1; k++) settle(1);
        `CHK(dll_locked_o, 1'b1)
        rd(8'h74);
        `CHK(rv, 8'h25)
        // slip holds the divider one clock, so the next output clock edge comes a clock late
        o2 = output_sample_clock_o;
        for (tn = 0; tn < 8 && output_sample_clock_o === o2; tn++) settle(1);
        wr(8'h70, 8'h0E);
        settle(0);
        o2 = output_sample_clock_o;
        for (tn = 0; tn < 8 && output_sample_clock_o === o2; tn++) settle(1);
        `CHK(tn, 3)
        wr(8'h71, 8'h05);
        settle(2);
        `CHK(power_state_o, AFC_PWR_SLEEP)
        `CHK({data_oe_o, over_range_oe_o, output_sample_clock_oe_o}, 3'b000)
        wr(8'h71, 8'h06);
        settle(2);
        `CHK(power_state_o, AFC_PWR_NAP)
        wr(8'h71, 8'h00);
        settle(3);
        `CHK({data_oe_o, over_range_oe_o, output_sample_clock_oe_o}, 3'b111)
        wr(8'h73, 8'h1C);
        settle(2);
        `CHK({cmos_mode_o, ddr_mode_o, lvds_low_drive_o}, 3'b110)
        // ddr at divide 4: upper half beside a high output clock, lower half one clock later
        settle(3);
        for (tn = 0; tn < 8 && output_sample_clock_o !== 1'b1; tn++) settle(1);
        `CHK(data_o, 14'h003F)
        settle(1);
        `CHK({output_sample_clock_o, data_o}, 15'h007F)
        rd(8'h73);
        `CHK(rv, 8'h1C)
        wr(8'h73, 8'h10);
        settle(2);
        `CHK({cmos_mode_o, ddr_mode_o, lvds_low_drive_o}, 3'b001)
        wr(8'h72, 8'h01);
        settle(2);
        `CHK(dll_slow_range_o, 1'b1)
        rd(8'h10);
        `CHK(rv, 8'h00)
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
